// >>> design/msd_cfg.svh
// constants for the metering status and data register bank
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
// register offsets, one per word address of the register port
`define MSD_OFF_SYS_STATUS 9'h0CA
`define MSD_OFF_INST_FREQ 9'h0CB
`define MSD_OFF_INST_P 9'h0CC
`define MSD_OFF_INST_Q 9'h0CD
`define MSD_OFF_INST_I 9'h0CE
`define MSD_OFF_INST_U 9'h0CF
`define MSD_OFF_AVG_P 9'h0D0
`define MSD_OFF_AVG_Q 9'h0D1
`define MSD_OFF_AVG_FREQ 9'h0D2
`define MSD_OFF_AVG_I 9'h0D3
`define MSD_OFF_FLAG_CLR 9'h19D
`define MSD_OFF_IRQ_MASK 9'h1F0
`define MSD_OFF_DATA_VALID 9'h1F1
// field positions
`define MSD_BIT_REF_LEAK 0
`define MSD_BIT_PHASE_DONE 9
`define MSD_BIT_POWERDOWN 6
`define MSD_VALID_RMS 0
`define MSD_VALID_PWR 1
`define MSD_VALID_AVG 2
// reset values
`define MSD_DATA_RST 32'h0000_0000
`define MSD_FLAG_RST 1'b0
`define MSD_MASK_RST 1'b0
// timing: clock rate, base tick and refresh periods in milliseconds
`define MSD_CLK_MHZ 20
`define MSD_BASE_US 10000
`define MSD_BASE_CYCLES (`MSD_BASE_US * `MSD_CLK_MHZ)
`define MSD_BASE_MS 10
`define MSD_RMS_MS 10
`define MSD_FREQ_MS 20
`define MSD_PWR_MS 160
`define MSD_AVGF_MS 320
`define MSD_AVGI_MS 320
`define MSD_AVGP_MS 640
`define MSD_RMS_SETTLE_MS 160
`define MSD_PWR_SETTLE_MS 480
`define MSD_AVG_SETTLE_MS 1280
`endif

// >>> design/msd_pkg.sv
// types shared by the metering status and data register bank
package msd_pkg;
    // raw results handed over by the metering datapath
    typedef struct packed {
        logic [31:0] freq;
        logic [31:0] p_inst;
        logic [31:0] q_inst;
        logic [31:0] i_rms;
        logic [31:0] u_rms;
        logic [31:0] p_avg;
        logic [31:0] q_avg;
        logic [31:0] freq_avg;
        logic [31:0] i_avg;
    } msd_meas_type;
    // one request on the register port
    typedef struct packed {
        logic [8:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } msd_req_type;
endpackage

// >>> design/msd_regs.sv
// metering status flags and read-only metering data registers
`timescale 1ns/100ps
`include "msd_cfg.svh"
module msd_regs
    import msd_pkg::*;
#(
    parameter int BASE_CYCLES = `MSD_BASE_CYCLES
)
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // further reset sources
    input wire logic rx_reset_in,
    input wire logic soft_reset_in,
    // register port
    input wire msd_req_type req_in,
    output logic [31:0] rdata_out,
    // analog and measurement events
    input wire logic ref_leak_in,
    input wire logic main_supply_low_in,
    input wire logic phase_done_in,
    input wire msd_meas_type meas_in,
    // interrupt
    output logic irq_out
);

    //------------------------------------------------------------
    // derived periods in base ticks
    //------------------------------------------------------------
    localparam logic [6:0] FREQ_MASK = 7'((`MSD_FREQ_MS / `MSD_BASE_MS) - 1);
    localparam logic [6:0] RMS_MASK = 7'((`MSD_RMS_MS / `MSD_BASE_MS) - 1);
    localparam logic [6:0] PWR_MASK = 7'((`MSD_PWR_MS / `MSD_BASE_MS) - 1);
    localparam logic [6:0] AVGF_MASK = 7'((`MSD_AVGF_MS / `MSD_BASE_MS) - 1);
    localparam logic [6:0] AVGI_MASK = 7'((`MSD_AVGI_MS / `MSD_BASE_MS) - 1);
    localparam logic [6:0] AVGP_MASK = 7'((`MSD_AVGP_MS / `MSD_BASE_MS) - 1);
    localparam logic [7:0] RMS_SETTLE = 8'(`MSD_RMS_SETTLE_MS / `MSD_BASE_MS);
    localparam logic [7:0] PWR_SETTLE = 8'(`MSD_PWR_SETTLE_MS / `MSD_BASE_MS);
    localparam logic [7:0] AVG_SETTLE = 8'(`MSD_AVG_SETTLE_MS / `MSD_BASE_MS);
    localparam logic [17:0] BASE_LAST = 18'(BASE_CYCLES - 1);

    // refresh is due when the low tick bits selected by the mask are all ones
    function automatic logic msd_due(input logic [6:0] cnt, input logic [6:0] mask);
        msd_due = ((cnt & mask) == mask);
    endfunction

    //------------------------------------------------------------
    // declarations
    //------------------------------------------------------------
    logic meter_clr;
    logic [17:0] base_cnt_reg;
    logic base_tick;
    logic [6:0] tick_cnt_reg;
    logic [7:0] settle_reg;
    logic [31:0] freq_reg;
    logic [31:0] p_inst_reg;
    logic [31:0] q_inst_reg;
    logic [31:0] i_rms_reg;
    logic [31:0] u_rms_reg;
    logic [31:0] p_avg_reg;
    logic [31:0] q_avg_reg;
    logic [31:0] freq_avg_reg;
    logic [31:0] i_avg_reg;
    logic flag_phase_reg;
    logic flag_pdn_reg;
    logic mask_phase_reg;
    logic mask_pdn_reg;
    logic clr_write;
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;

    // either synchronous reset source restarts the metering side
    assign meter_clr = rx_reset_in | soft_reset_in;
    assign base_tick = (base_cnt_reg == BASE_LAST);
    assign clr_write = req_in.wr && (req_in.addr == `MSD_OFF_FLAG_CLR);

    //------------------------------------------------------------
    // base timer
    //------------------------------------------------------------
    // one tick per 10 ms; shorten BASE_CYCLES in simulation
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            base_cnt_reg <= 18'h00000;
        else if (meter_clr || base_tick)
            base_cnt_reg <= 18'h00000;
        else
            base_cnt_reg <= base_cnt_reg + 18'h00001;
    end

    // free tick count; all refresh periods are powers of two of the base
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            tick_cnt_reg <= 7'h00;
        else if (meter_clr)
            tick_cnt_reg <= 7'h00;
        else if (base_tick)
            tick_cnt_reg <= tick_cnt_reg + 7'h01;
    end

    // settling age in ticks, saturating so it never wraps back to invalid
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            settle_reg <= 8'h00;
        else if (meter_clr)
            settle_reg <= 8'h00;
        else if (base_tick && (settle_reg < AVG_SETTLE))
            settle_reg <= settle_reg + 8'h01;
    end

    //------------------------------------------------------------
    // metering data registers
    //------------------------------------------------------------
    // each register samples the datapath only at its own refresh point
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            freq_reg <= `MSD_DATA_RST;
            p_inst_reg <= `MSD_DATA_RST;
            q_inst_reg <= `MSD_DATA_RST;
            i_rms_reg <= `MSD_DATA_RST;
            u_rms_reg <= `MSD_DATA_RST;
            p_avg_reg <= `MSD_DATA_RST;
            q_avg_reg <= `MSD_DATA_RST;
            freq_avg_reg <= `MSD_DATA_RST;
            i_avg_reg <= `MSD_DATA_RST;
        end
        else if (meter_clr)
        begin
            freq_reg <= `MSD_DATA_RST;
            p_inst_reg <= `MSD_DATA_RST;
            q_inst_reg <= `MSD_DATA_RST;
            i_rms_reg <= `MSD_DATA_RST;
            u_rms_reg <= `MSD_DATA_RST;
            p_avg_reg <= `MSD_DATA_RST;
            q_avg_reg <= `MSD_DATA_RST;
            freq_avg_reg <= `MSD_DATA_RST;
            i_avg_reg <= `MSD_DATA_RST;
        end
        else if (base_tick)
        begin
            if (msd_due(tick_cnt_reg, FREQ_MASK))
                freq_reg <= meas_in.freq;
            if (msd_due(tick_cnt_reg, PWR_MASK))
            begin
                p_inst_reg <= meas_in.p_inst;
                q_inst_reg <= meas_in.q_inst;
            end
            if (msd_due(tick_cnt_reg, RMS_MASK))
            begin
                i_rms_reg <= meas_in.i_rms;
                u_rms_reg <= meas_in.u_rms;
            end
            if (msd_due(tick_cnt_reg, AVGP_MASK))
            begin
                p_avg_reg <= meas_in.p_avg;
                q_avg_reg <= meas_in.q_avg;
            end
            if (msd_due(tick_cnt_reg, AVGF_MASK))
                freq_avg_reg <= meas_in.freq_avg;
            if (msd_due(tick_cnt_reg, AVGI_MASK))
                i_avg_reg <= meas_in.i_avg;
        end
    end

    //------------------------------------------------------------
    // latched flags and interrupt
    //------------------------------------------------------------
    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            flag_phase_reg <= `MSD_FLAG_RST;
        else if (phase_done_in)
            flag_phase_reg <= 1'b1;
        else if (clr_write && req_in.wdata[`MSD_BIT_PHASE_DONE])
            flag_phase_reg <= 1'b0;
    end

    // a supply that stays low keeps the flag set through any clear
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            flag_pdn_reg <= `MSD_FLAG_RST;
        else if (main_supply_low_in)
            flag_pdn_reg <= 1'b1;
        else if (clr_write && req_in.wdata[`MSD_BIT_POWERDOWN])
            flag_pdn_reg <= 1'b0;
    end

    // mask register shares the flag layout
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mask_phase_reg <= `MSD_MASK_RST;
            mask_pdn_reg <= `MSD_MASK_RST;
        end
        else if (req_in.wr && (req_in.addr == `MSD_OFF_IRQ_MASK))
        begin
            mask_phase_reg <= req_in.wdata[`MSD_BIT_PHASE_DONE];
            mask_pdn_reg <= req_in.wdata[`MSD_BIT_POWERDOWN];
        end
    end

    // level interrupt while any enabled flag stands
    assign irq_out = (flag_phase_reg & mask_phase_reg) | (flag_pdn_reg & mask_pdn_reg);

    //------------------------------------------------------------
    // read path
    //------------------------------------------------------------
    // unmapped and reserved bits read zero; data only in the next cycle
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (req_in.addr)
            `MSD_OFF_SYS_STATUS:
                rdata_next[`MSD_BIT_REF_LEAK] = ref_leak_in;
            `MSD_OFF_INST_FREQ:
                rdata_next = freq_reg;
            `MSD_OFF_INST_P:
                rdata_next = p_inst_reg;
            `MSD_OFF_INST_Q:
                rdata_next = q_inst_reg;
            `MSD_OFF_INST_I:
                rdata_next = i_rms_reg;
            `MSD_OFF_INST_U:
                rdata_next = u_rms_reg;
            `MSD_OFF_AVG_P:
                rdata_next = p_avg_reg;
            `MSD_OFF_AVG_Q:
                rdata_next = q_avg_reg;
            `MSD_OFF_AVG_FREQ:
                rdata_next = freq_avg_reg;
            `MSD_OFF_AVG_I:
                rdata_next = i_avg_reg;
            `MSD_OFF_FLAG_CLR:
            begin
                rdata_next[`MSD_BIT_PHASE_DONE] = flag_phase_reg;
                rdata_next[`MSD_BIT_POWERDOWN] = flag_pdn_reg;
            end
            `MSD_OFF_IRQ_MASK:
            begin
                rdata_next[`MSD_BIT_PHASE_DONE] = mask_phase_reg;
                rdata_next[`MSD_BIT_POWERDOWN] = mask_pdn_reg;
            end
            `MSD_OFF_DATA_VALID:
            begin
                rdata_next[`MSD_VALID_RMS] = (settle_reg >= RMS_SETTLE);
                rdata_next[`MSD_VALID_PWR] = (settle_reg >= PWR_SETTLE);
                rdata_next[`MSD_VALID_AVG] = (settle_reg >= AVG_SETTLE);
            end
            default:
                rdata_next = 32'h0000_0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_reg <= 32'h0000_0000;
        else if (req_in.rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 32'h0000_0000;
    end

    assign rdata_out = rdata_reg;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    a_ref_bit_live:
        assert property (req_in.rd && (req_in.addr == `MSD_OFF_SYS_STATUS)
            |=> rdata_out[`MSD_BIT_REF_LEAK] == $past(ref_leak_in))
        else $error("system status bit 0 does not follow leak input");

    a_phase_flag_set:
        assert property (phase_done_in |=> flag_phase_reg [*1] ##1 1'b1)
        else $error("phase done flag not set");

    a_pdn_flag_set:
        assert property (main_supply_low_in |=> flag_pdn_reg)
        else $error("power-down flag not set");

    a_reserved_bits_zero:
        assert property (req_in.rd && (req_in.addr == `MSD_OFF_FLAG_CLR)
            |=> (rdata_out[31:10] == 22'h000000) && (rdata_out[8:7] == 2'h0)
            && (rdata_out[5:0] == 6'h00))
        else $error("reserved flag bits not zero");

    a_reset_clears_data:
        assert property (meter_clr |=> (freq_reg == 32'h0000_0000)
            && (i_rms_reg == 32'h0000_0000) && (i_avg_reg == 32'h0000_0000)
            && (settle_reg == 8'h00))
        else $error("data not cleared by reset source");

    a_freq_held:
        assert property (!(base_tick && tick_cnt_reg[0]) && !meter_clr |=> $stable(freq_reg))
        else $error("frequency changed outside its refresh");

    a_avg_freq_load:
        assert property (base_tick && (tick_cnt_reg[4:0] == 5'h1F) && !meter_clr
            |=> freq_avg_reg == $past(meas_in.freq_avg))
        else $error("average frequency not refreshed");

    a_power_load:
        assert property (base_tick && (tick_cnt_reg[3:0] == 4'hF) && !meter_clr
            |=> (p_inst_reg == $past(meas_in.p_inst)) && (q_inst_reg == $past(meas_in.q_inst)))
        else $error("instantaneous power not refreshed");

    a_rms_load:
        assert property (base_tick && !meter_clr
            |=> (u_rms_reg == $past(meas_in.u_rms)) && (i_rms_reg == $past(meas_in.i_rms)))
        else $error("rms not refreshed on base tick");

    a_avg_power_held:
        assert property (!(base_tick && (tick_cnt_reg[5:0] == 6'h3F)) && !meter_clr
            |=> $stable(p_avg_reg) && $stable(q_avg_reg))
        else $error("average power changed outside its refresh");

    a_avg_current_load:
        assert property (base_tick && (tick_cnt_reg[4:0] == 5'h1F) && !meter_clr
            |=> i_avg_reg == $past(meas_in.i_avg))
        else $error("average current not refreshed");

    a_flag_clear_write:
        assert property (clr_write && req_in.wdata[`MSD_BIT_PHASE_DONE] && !phase_done_in
            |=> !flag_phase_reg ##1 (flag_phase_reg == $past(phase_done_in)))
        else $error("phase flag clear or re-set wrong");

    a_irq_level:
        assert property ((flag_pdn_reg && mask_pdn_reg) |-> irq_out)
        else $error("interrupt low with enabled flag set");

endmodule

// >>> test/msd_host.sv
// host model that reaches the register bank over its request port
`timescale 1ns/100ps
`include "msd_cfg.svh"
module msd_host
    import msd_pkg::*;
(
    // clock
    input wire logic clock_in,
    // register port
    output msd_req_type req_out,
    input wire logic [31:0] rdata_in
);
    // idle from time zero so the block never sees an unknown strobe
    initial
    begin
        req_out = '0;
    end

    // one write cycle; the strobe drops at the edge that takes it
    task automatic wr(input logic [8:0] addr, input logic [31:0] data);
        @(posedge clock_in);
        req_out <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        req_out <= '0;
    endtask

    // read data stand only in the cycle after the taking edge
    task automatic rd(input logic [8:0] addr, output logic [31:0] data);
        @(posedge clock_in);
        req_out <= '{addr: addr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        req_out <= '0;
        #1;
        data = rdata_in;
    endtask

    // reserved flag bits carry nothing, so they are ignored here
    task automatic rd_flags(output logic [31:0] data);
        rd(`MSD_OFF_FLAG_CLR, data);
        data = data & 32'h0000_0240;
    endtask

    // a one written at a flag's own position clears it
    task automatic clear_flags(input logic [31:0] bits);
        wr(`MSD_OFF_FLAG_CLR, bits);
    endtask
endmodule

// >>> test/msd_regs_tb.sv
// self-checking testbench for the metering status and data register bank
`timescale 1ns/100ps
`include "msd_cfg.svh"
module msd_regs_tb;
    import msd_pkg::*;
    // ----------------------------------------
    // signals and bookkeeping
    // ----------------------------------------
    // short base tick keeps the 64-tick refresh test near 2600 cycles
    localparam int BC = 40;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic rx_reset_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic ref_leak_in = 1'b0;
    logic main_supply_low_in = 1'b0;
    logic phase_done_in = 1'b0;
    msd_meas_type meas_in;
    msd_req_type req;
    logic [31:0] rdata_out;
    logic irq_out;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int t0 = 0;
    logic [31:0] d;
    int period [9] = '{2, 16, 16, 1, 1, 64, 64, 32, 32};
    int marks [9] = '{0, 1, 2, 15, 16, 31, 32, 63, 64};

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    always #25 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;

    msd_regs #(.BASE_CYCLES(BC)) dut (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .rx_reset_in(rx_reset_in),
        .soft_reset_in(soft_reset_in),
        .req_in(req),
        .rdata_out(rdata_out),
        .ref_leak_in(ref_leak_in),
        .main_supply_low_in(main_supply_low_in),
        .phase_done_in(phase_done_in),
        .meas_in(meas_in),
        .irq_out(irq_out)
    );

    msd_host host (
        .clock_in(clock_in),
        .req_out(req),
        .rdata_in(rdata_out)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // distinct value per result so a swapped register shows up
    function automatic logic [31:0] val(input int i);
        return 32'h5A5A_0100 + 32'(i);
    endfunction

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rdchk(input string what, input logic [8:0] a, input logic [31:0] exp);
        host.rd(a, d);
        chk32(what, exp, d);
    endtask

    // one-cycle pulse on a sync input; t0 marks the edge that took it
    task automatic strobe(input int which);
        @(posedge clock_in);
        case (which)
            0: rx_reset_in <= 1'b1;
            1: soft_reset_in <= 1'b1;
            2: phase_done_in <= 1'b1;
            default: main_supply_low_in <= 1'b1;
        endcase
        @(posedge clock_in);
        {rx_reset_in, soft_reset_in, phase_done_in, main_supply_low_in} <= 4'h0;
        t0 = cyc;
    endtask

    // reads start a quarter tick after tick k and end before tick k+1
    task automatic wait_ticks(input int k);
        while (cyc - t0 < BC * k + 10)
            @(posedge clock_in);
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        for (int i = 0; i < 9; i++)
            meas_in[287 - 32 * i -: 32] = val(i);
        repeat (4) @(posedge clock_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdchk("data default", 9'h0CB + 9'(i), 32'h0);
        rdchk("flag default", `MSD_OFF_FLAG_CLR, 32'h0);
        rdchk("mask default", `MSD_OFF_IRQ_MASK, 32'h0);
        rdchk("unmapped", 9'h1FF, 32'h0);
        $display("test defaults done");

        ref_leak_in <= 1'b1;
        rdchk("leak high", `MSD_OFF_SYS_STATUS, 32'h1);
        host.wr(`MSD_OFF_SYS_STATUS, 32'h0);
        rdchk("leak after write", `MSD_OFF_SYS_STATUS, 32'h1);
        ref_leak_in <= 1'b0;
        rdchk("leak low", `MSD_OFF_SYS_STATUS, 32'h0);
        $display("test leak done");

        // refresh points at tick boundaries; a write to a data place is refused
        strobe(0);
        host.wr(`MSD_OFF_AVG_P, 32'hFFFF_FFFF);
        foreach (marks[m])
        begin
            wait_ticks(marks[m]);
            for (int i = 0; i < 9; i++)
                rdchk("refresh", 9'h0CB + 9'(i), marks[m] >= period[i] ? val(i) : 32'h0);
            rdchk("valid", `MSD_OFF_DATA_VALID,
                {29'h0, marks[m] >= 128, marks[m] >= 48, marks[m] >= 16});
        end
        $display("test refresh done");

        // flags, mask and level interrupt
        strobe(2);
        host.rd_flags(d);
        chk32("phase flag", 32'h200, d);
        chk1("irq masked", 1'b0, irq_out);
        host.wr(`MSD_OFF_IRQ_MASK, 32'h240);
        host.rd_flags(d);
        chk1("irq raised", 1'b1, irq_out);
        host.clear_flags(32'h40);
        host.rd_flags(d);
        chk32("other bit kept", 32'h200, d);
        host.clear_flags(32'h200);
        host.rd_flags(d);
        chk32("phase cleared", 32'h0, d);
        chk1("irq dropped", 1'b0, irq_out);
        strobe(3);
        host.rd_flags(d);
        chk32("power-down flag", 32'h40, d);
        chk1("irq power-down", 1'b1, irq_out);
        $display("test flags done");

        // data resets clear data registers, flags stay
        strobe(0);
        host.rd_flags(d);
        chk32("flag after rx reset", 32'h40, d);
        rdchk("data after rx reset", `MSD_OFF_AVG_P, 32'h0);
        strobe(1);
        rdchk("data after soft reset", `MSD_OFF_INST_I, 32'h0);
        rdchk("freq after soft reset", `MSD_OFF_INST_FREQ, 32'h0);
        host.clear_flags(32'h40);
        repeat (5) @(posedge clock_in);
        host.rd_flags(d);
        chk32("flag stays clear", 32'h0, d);
        chk1("irq clear", 1'b0, irq_out);
        $display("test resets done");
        summarize();
    end

    // the whole run needs about 3000 cycles
    initial
    begin
        #(50 * 10000);
        fail_count++;
        $display("watchdog expired");
        summarize();
    end
endmodule
